/* File: shared/flash_ctl_pkg.sv */
`default_nettype none
package flash_ctl_pkg;
  // wishbone register word offsets (byte addresses)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_DATA = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hC;
  // control fields
  localparam int CTRL_GO_POS = 0;
  localparam int CTRL_CMD_POS = 1;
  localparam int CTRL_STOP_POS = 3;
  localparam int CTRL_MASK_POS = 4;
  // status fields
  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_DONE_POS = 2;
  localparam int STAT_FAIL_POS = 3;
  localparam int STAT_REJ_POS = 4;
  localparam logic [2:0] MASK_RESET = 3'h0;
  // flash data bits
  localparam int DATA_POLL_POS = 7;
  localparam int TOGGLE_POS = 6;
  localparam int TIMEOUT_POS = 5;
  localparam int ERASE_WIN_POS = 3;
  // command codes
  localparam logic [7:0] CODE_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
  localparam logic [7:0] CODE_SETUP = 8'h80;
  localparam logic [7:0] CODE_CHIP = 8'h10;
  localparam logic [7:0] CODE_SECTOR = 8'h30;
  localparam logic [7:0] CODE_PROGRAM = 8'hA0;
  localparam logic [7:0] CODE_RESET = 8'hF0;
  localparam logic [19:0] ADDR_UNLOCK1 = 20'h00555;
  localparam logic [19:0] ADDR_UNLOCK2 = 20'h002AA;
  // bus timing: 100 ns clock
  localparam int CLK_NS = 100;
  localparam int WRITE_PULSE_NS = 45;
  localparam int READ_ACCESS_NS = 90;
  localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_CYC = (READ_ACCESS_NS + CLK_NS - 1) / CLK_NS + 1;
  localparam logic [1:0] PULSE_CNT_RESET = 2'h0;
  typedef enum logic [1:0] {
    OP_CHIP, OP_SECTOR, OP_ADD_SECTOR, OP_PROGRAM
  } op_t;
endpackage : flash_ctl_pkg
`default_nettype wire

/* File: rtl/flash_ctl.sv */
`default_nettype none
module flash_ctl
  import flash_ctl_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  output logic [19:0] flash_addr,
  output logic [7:0] flash_dq_o,
  output logic flash_dq_oe,
  input wire logic [7:0] flash_dq_i,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic unprotect_en,
  input wire logic ready_busy_n
);
  import flash_ctl_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_WR_LOW, S_WR_HIGH, S_RD_LOW, S_RD_DONE, S_DECIDE
  } state_t;

  state_t state;
  logic [2:0] step;
  logic [2:0] last_step;
  op_t op;
  logic [19:0] target;
  logic [7:0] program_byte;
  logic [1:0] cnt;
  logic [7:0] prev_rd;
  logic [7:0] cur_rd;
  logic have_prev;
  logic recheck;
  logic use_toggle;
  logic win_before;
  logic pre_check;
  logic [2:0] status;
  logic [2:0] mask;
  logic ev_done;
  logic ev_fail;
  logic ev_rej;
  logic wb_hit;

  // address and data of each write in the sequence
  function automatic logic [27:0] seq_word(input logic [2:0] s,
      input op_t o, input logic [19:0] t, input logic [7:0] pd);
    unique case (s)
      3'h0: seq_word = {ADDR_UNLOCK1, CODE_UNLOCK1};
      3'h1: seq_word = {ADDR_UNLOCK2, CODE_UNLOCK2};
      3'h2: seq_word = (o == OP_PROGRAM) ? {ADDR_UNLOCK1, CODE_PROGRAM}
                                         : {ADDR_UNLOCK1, CODE_SETUP};
      3'h3: seq_word = (o == OP_PROGRAM) ? {t, pd}
                                         : {ADDR_UNLOCK1, CODE_UNLOCK1};
      3'h4: seq_word = {ADDR_UNLOCK2, CODE_UNLOCK2};
      3'h5: seq_word = (o == OP_CHIP) ? {ADDR_UNLOCK1, CODE_CHIP}
                                      : {t, CODE_SECTOR};
      3'h6: seq_word = {t, CODE_SECTOR};
      default: seq_word = {ADDR_UNLOCK1, CODE_RESET};
    endcase
  endfunction : seq_word

  function automatic logic in_range(input logic [1:0] c, input int n);
    in_range = (int'(c) + 1 >= n);
  endfunction : in_range

  logic [27:0] next_word;
  assign next_word = seq_word(step + 3'h1, op, target, program_byte);
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // wishbone slave: one wait, ack one cycle later
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= 32'h00000000;
      if (wb_hit && !wb_we_i) begin
        unique case (wb_adr_i)
          REG_CTRL: wb_dat_o <= {24'h0, unprotect_en, mask, use_toggle, op,
                                 1'b0};
          REG_ADDR: wb_dat_o <= {12'h000, target};
          REG_DATA: wb_dat_o <= {16'h0000, cur_rd, program_byte};
          REG_STAT: wb_dat_o <= {27'h0, status, ready_busy_n,
                                 state != S_IDLE};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      target <= 20'h00000;
      program_byte <= 8'h00;
      mask <= MASK_RESET;
      unprotect_en <= 1'b0;
    end else if (wb_hit && wb_we_i) begin
      if (wb_adr_i == REG_ADDR && wb_sel_i[0])
        target[7:0] <= wb_dat_i[7:0];
      if (wb_adr_i == REG_ADDR && wb_sel_i[1])
        target[15:8] <= wb_dat_i[15:8];
      if (wb_adr_i == REG_ADDR && wb_sel_i[2])
        target[19:16] <= wb_dat_i[19:16];
      if (wb_adr_i == REG_DATA && wb_sel_i[0])
        program_byte <= wb_dat_i[7:0];
      if (wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
        mask <= wb_dat_i[CTRL_MASK_POS +: 3];
        unprotect_en <= wb_dat_i[7];
      end
    end
  end

  // status: set wins over write-one-to-clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status <= 3'h0;
      irq <= 1'b0;
    end else begin
      logic [2:0] clr;
      clr = 3'h0;
      if (wb_hit && wb_we_i && wb_adr_i == REG_STAT && wb_sel_i[0])
        clr = wb_dat_i[STAT_REJ_POS:STAT_DONE_POS];
      status <= (status & ~clr) | {ev_rej, ev_fail, ev_done};
      irq <= |(((status & ~clr) | {ev_rej, ev_fail, ev_done}) & mask);
    end
  end

  logic start;
  assign start = wb_hit && wb_we_i && wb_adr_i == REG_CTRL &&
                 wb_sel_i[0] && wb_dat_i[CTRL_GO_POS] && state == S_IDLE;

  // sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= S_IDLE;
      step <= 3'h0;
      last_step <= 3'h0;
      op <= OP_CHIP;
      cnt <= PULSE_CNT_RESET;
      prev_rd <= 8'h00;
      cur_rd <= 8'h00;
      have_prev <= 1'b0;
      recheck <= 1'b0;
      use_toggle <= 1'b0;
      win_before <= 1'b0;
      pre_check <= 1'b0;
      ev_done <= 1'b0;
      ev_fail <= 1'b0;
      ev_rej <= 1'b0;
      flash_addr <= 20'h00000;
      flash_dq_o <= 8'h00;
      flash_dq_oe <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
    end else begin
      ev_done <= 1'b0;
      ev_fail <= 1'b0;
      ev_rej <= 1'b0;
      unique case (state)
        S_IDLE: begin
          if (start) begin
            op <= op_t'(wb_dat_i[CTRL_CMD_POS +: 2]);
            use_toggle <= wb_dat_i[CTRL_STOP_POS];
            have_prev <= 1'b0;
            recheck <= 1'b0;
            cnt <= PULSE_CNT_RESET;
            unique case (op_t'(wb_dat_i[CTRL_CMD_POS +: 2]))
              OP_CHIP: begin
                step <= 3'h0;
                last_step <= 3'h5;
              end
              OP_SECTOR: begin
                step <= 3'h0;
                last_step <= 3'h5;
              end
              OP_PROGRAM: begin
                step <= 3'h0;
                last_step <= 3'h3;
              end
              OP_ADD_SECTOR: begin
                step <= 3'h6;
                last_step <= 3'h6;
              end
            endcase
            if (op_t'(wb_dat_i[CTRL_CMD_POS +: 2]) == OP_ADD_SECTOR) begin
              pre_check <= 1'b1;
              flash_addr <= target;
              flash_ce_n <= 1'b0;
              flash_oe_n <= 1'b0;
              state <= S_RD_LOW;
            end else begin
              pre_check <= 1'b0;
              flash_addr <= ADDR_UNLOCK1;
              flash_dq_o <= CODE_UNLOCK1;
              flash_dq_oe <= 1'b1;
              flash_ce_n <= 1'b0;
              flash_we_n <= 1'b0;
              state <= S_WR_LOW;
            end
          end
        end
        S_WR_LOW: begin
          cnt <= cnt + 2'h1;
          if (in_range(cnt, WRITE_PULSE_CYC)) begin
            flash_we_n <= 1'b1; // data latched on rising strobe
            flash_ce_n <= 1'b1;
            cnt <= PULSE_CNT_RESET;
            state <= S_WR_HIGH;
          end
        end
        S_WR_HIGH: begin
          flash_dq_oe <= 1'b0;
          if (step == last_step) begin
            // poll at program byte or inside the sector
            flash_addr <= target;
            flash_ce_n <= 1'b0;
            flash_oe_n <= 1'b0;
            state <= S_RD_LOW;
          end else begin
            step <= step + 3'h1;
            flash_addr <= next_word[27:8];
            flash_dq_o <= next_word[7:0];
            flash_dq_oe <= 1'b1;
            flash_ce_n <= 1'b0;
            flash_we_n <= 1'b0;
            state <= S_WR_LOW;
          end
        end
        S_RD_LOW: begin
          cnt <= cnt + 2'h1;
          if (in_range(cnt, READ_CYC)) begin
            cur_rd <= flash_dq_i;
            flash_oe_n <= 1'b1;
            flash_ce_n <= 1'b1;
            cnt <= PULSE_CNT_RESET;
            state <= S_DECIDE;
          end
        end
        S_DECIDE: begin
          logic busy;
          busy = 1'b0;
          prev_rd <= cur_rd;
          have_prev <= 1'b1;
          if (use_toggle)
            busy = !have_prev ||
                   (prev_rd[TOGGLE_POS] != cur_rd[TOGGLE_POS]);
          else if (op == OP_PROGRAM)
            busy = cur_rd[DATA_POLL_POS] !=
                   program_byte[DATA_POLL_POS];
          else
            busy = !cur_rd[DATA_POLL_POS];
          if (pre_check) begin
            win_before <= cur_rd[ERASE_WIN_POS];
            pre_check <= 1'b0;
            if (cur_rd[ERASE_WIN_POS]) begin
              ev_rej <= 1'b1; // window closed, skip the write
              state <= S_IDLE;
            end else begin
              flash_addr <= target;
              flash_dq_o <= CODE_SECTOR;
              flash_dq_oe <= 1'b1;
              flash_ce_n <= 1'b0;
              flash_we_n <= 1'b0;
              state <= S_WR_LOW;
            end
          end else if (op == OP_ADD_SECTOR) begin
            if (cur_rd[ERASE_WIN_POS])
              ev_rej <= 1'b1;
            else
              ev_done <= 1'b1;
            state <= S_IDLE;
          end else if (!busy && have_prev | !use_toggle) begin
            ev_done <= 1'b1;
            state <= S_IDLE;
          end else if (recheck) begin
            ev_fail <= 1'b1;
            flash_addr <= ADDR_UNLOCK1;
            step <= 3'h7;
            last_step <= 3'h7;
            op <= OP_CHIP;
            flash_dq_o <= CODE_RESET;
            flash_dq_oe <= 1'b1;
            flash_ce_n <= 1'b0;
            flash_we_n <= 1'b0;
            state <= S_WR_LOW;
          end else begin
            if (cur_rd[TIMEOUT_POS])
              recheck <= 1'b1;
            flash_ce_n <= 1'b0;
            flash_oe_n <= 1'b0;
            state <= S_RD_LOW;
          end
        end
        default: state <= S_IDLE;
      endcase
      if (state == S_WR_HIGH && step == 3'h7) begin
        flash_ce_n <= 1'b1;
        flash_oe_n <= 1'b1;
        state <= S_IDLE;
      end
    end
  end

  a_fail_needs_recheck: assert property (@(posedge clk) disable iff (!rst_b)
    ev_fail |-> $past(recheck))
    else $error("fail without timeout recheck");
  a_poll_at_target: assert property (@(posedge clk) disable iff (!rst_b)
    (state == S_RD_LOW && op != OP_CHIP) |-> flash_addr == target)
    else $error("poll address is not the target");
  a_no_read_write: assert property (@(posedge clk) disable iff (!rst_b)
    !(!flash_we_n && !flash_oe_n))
    else $error("write and read strobes together");
  a_write_strobe_len: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(flash_we_n) |=> flash_we_n && flash_ce_n)
    else $error("write strobe width wrong");
  a_chip_last_cmd: assert property (@(posedge clk) disable iff (!rst_b)
    (state == S_WR_LOW && step == 3'h5 && op == OP_CHIP) |->
      flash_dq_o == CODE_CHIP && flash_addr == ADDR_UNLOCK1)
    else $error("chip erase sixth write wrong");
  a_sector_last_cmd: assert property (@(posedge clk) disable iff (!rst_b)
    (state == S_WR_LOW && step == 3'h5 && op == OP_SECTOR) |->
      flash_dq_o == CODE_SECTOR && flash_addr == target)
    else $error("sector erase sixth write wrong");
  a_add_needs_window: assert property (@(posedge clk) disable iff (!rst_b)
    (state == S_WR_LOW && op == OP_ADD_SECTOR) |-> !win_before)
    else $error("extra sector written after window closed");
  a_done_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    ev_done |=> !ev_done && state == S_IDLE)
    else $error("done event not a single pulse");
endmodule : flash_ctl
`default_nettype wire

/* File: bench/flash_model.sv */
`default_nettype none
module flash_model
  import flash_ctl_pkg::*;
#(parameter int BUSY_CYC = 40)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [19:0] flash_addr,
  input wire logic [7:0] flash_dq_o,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic unprotect_en,
  input wire logic win_closed,
  input wire logic stuck,
  output logic [7:0] flash_dq_i,
  output logic ready_busy_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [19:0] la [0:63];
  logic [7:0] ld [0:63];
  int n;
  int cnt;
  logic busy, prog, tog, wr_q, rd_q, open_groups;
  logic [19:0] a_q, ra;
  logic [7:0] d_q, pd, last;
  // groups stay open only while the controller asks for it
  assign open_groups = unprotect_en;
  assign ready_busy_n = !busy;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      n <= 0;
      cnt <= 0;
      {busy, prog, tog, wr_q, rd_q} <= 5'h00;
      {a_q, d_q, pd, last} <= '0;
      ra <= 20'h00000;
    end else begin
      wr_q <= !flash_we_n && !flash_ce_n;
      rd_q <= !flash_oe_n && !flash_ce_n;
      a_q <= flash_addr;
      d_q <= flash_dq_o;
      if (busy && !stuck && cnt > 0) cnt <= cnt - 1;
      if (busy && !stuck && cnt == 1) busy <= 1'b0;
      if (!flash_oe_n && !flash_ce_n) last <= flash_dq_i;
      if (!flash_oe_n && !flash_ce_n) ra <= flash_addr;
      if (rd_q && (flash_oe_n || flash_ce_n) && busy) tog <= ~tog;
      if (wr_q && (flash_we_n || flash_ce_n)) begin
        la[n] <= a_q;
        ld[n] <= d_q;
        n <= n + 1;
        if (n > 1 && ld[n-1] == CODE_PROGRAM && ld[n-2] == CODE_UNLOCK2) begin
          {busy, prog, pd, cnt} <= {2'b11, d_q, BUSY_CYC};
        end else if (d_q == CODE_SECTOR || d_q == CODE_CHIP) begin
          {busy, prog, cnt} <= {2'b10, BUSY_CYC};
        end else if (d_q == CODE_RESET) begin
          busy <= 1'b0;
        end
      end
    end
  end
  always_comb begin
    // a released bus shows the inverse of the last value, never a copy
    if (flash_oe_n || flash_ce_n) flash_dq_i = ~last;
    else if (busy)
      flash_dq_i = {prog & ~pd[7], tog, stuck, 1'b0, win_closed, 3'h0};
    else if (prog) flash_dq_i = pd;
    else flash_dq_i = {4'hF, win_closed, 3'h7};
  end
endmodule : flash_model
`default_nettype wire

/* File: bench/flash_ctl_test.sv */
`default_nettype none
module flash_ctl_test;
  import flash_ctl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_b = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic wb_ack_o, irq, flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n;
  logic unprotect_en, ready_busy_n, win = 0, stuck = 0;
  logic [19:0] flash_addr, t;
  logic [7:0] flash_dq_o, flash_dq_i, pd;
  int fails = 0, checked = 0, cycles = 0, n0;
  always #50 clk = ~clk;
  flash_ctl u_dut (.clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .flash_addr,
    .flash_dq_o, .flash_dq_oe, .flash_dq_i, .flash_ce_n, .flash_we_n,
    .flash_oe_n, .unprotect_en, .ready_busy_n);
  flash_model u_flash (.clk, .rst_b, .flash_addr, .flash_dq_o, .flash_ce_n,
    .flash_we_n, .flash_oe_n, .unprotect_en, .win_closed(win), .stuck,
    .flash_dq_i, .ready_busy_n);
  task automatic print_verdict;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb
  function automatic logic [27:0] exp_w(input logic [1:0] op, input int i);
    if (op == 2'd3 && i == 3) return {t, pd};
    case (i)
      0, 3: return {ADDR_UNLOCK1, CODE_UNLOCK1};
      1, 4: return {ADDR_UNLOCK2, CODE_UNLOCK2};
      2: return {ADDR_UNLOCK1, op == 2'd3 ? CODE_PROGRAM : CODE_SETUP};
      default: return op == 2'd0 ? {ADDR_UNLOCK1, CODE_CHIP} : {t, CODE_SECTOR};
    endcase
  endfunction : exp_w
  // start one operation and wait until both controller and flash are idle
  task automatic run(input logic [1:0] op, input logic tg, input logic [2:0] m);
    int k;
    n0 = u_flash.n;
    wb(1'b1, REG_ADDR, {12'h0, t});
    wb(1'b1, REG_DATA, {24'h0, pd});
    wb(1'b1, REG_CTRL, {24'h0, 1'b0, m, tg, op, 1'b1});
    k = 0;
    do begin
      wb(1'b0, REG_STAT, 32'h0);
      k++;
    end while ((q[0] !== 1'b0 || ready_busy_n !== 1'b1) && k < 500);
    repeat (2) @(posedge clk);
    // fresh status read: done and reject bits land one cycle after busy drops
    wb(1'b0, REG_STAT, 32'h0);
    chk(q[1:0], 2'b10);
  endtask : run
  task automatic chk_log(input logic [1:0] op);
    chk(u_flash.n - n0, op == 2'd3 ? 4 : 6);
    for (int i = 0; i < (op == 2'd3 ? 4 : 6); i++)
      chk({u_flash.la[n0+i], u_flash.ld[n0+i]}, exp_w(op, i));
  endtask : chk_log
  task automatic clear;
    wb(1'b1, REG_STAT, 32'h1E);
    repeat (2) @(posedge clk);
    chk(irq, 0);
  endtask : clear
  initial begin
    void'($urandom(36880));
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    wb(1'b1, REG_CTRL, 32'h80);
    chk(unprotect_en, 1);
    wb(1'b1, REG_CTRL, 32'h0);
    chk(unprotect_en, 0);
    for (int op = 0; op < 2; op++) begin
      t = 20'($urandom);
      pd = 8'($urandom);
      run(op[1:0], 1'b0, 3'h7);
      chk(irq, 1);
      chk(q[STAT_REJ_POS:STAT_DONE_POS], 3'b001);
      chk(u_flash.ra, t);
      chk_log(op[1:0]);
      clear();
    end
    run(2'd2, 1'b1, 3'h7);
    chk(u_flash.n - n0, 1);
    chk({u_flash.la[n0], u_flash.ld[n0]}, {t, CODE_SECTOR});
    chk(q[STAT_REJ_POS:STAT_DONE_POS], 3'b001);
    clear();
    win <= 1'b1;
    run(2'd2, 1'b0, 3'h7);
    chk(u_flash.n - n0, 0);
    chk(irq, 1);
    chk(q[STAT_REJ_POS:STAT_DONE_POS], 3'b100);
    clear();
    win <= 1'b0;
    for (int tg = 0; tg < 3; tg++) begin
      t = 20'($urandom);
      pd = 8'($urandom);
      run(2'd3, tg[0], tg < 2 ? 3'h7 : 3'h0);
      chk(irq, tg < 2);
      chk(q[STAT_REJ_POS:STAT_DONE_POS], 3'b001);
      chk_log(2'd3);
      chk(u_flash.ra, t);
      wb(1'b0, REG_DATA, 32'h0);
      chk(q[15:0], {pd, pd});
      clear();
    end
    // a stuck device, once with each polling method
    for (int tg = 0; tg < 2; tg++) begin
      stuck <= 1'b1;
      run(2'd1, tg[0], 3'h7);
      stuck <= 1'b0;
      chk(irq, 1);
      chk(q[STAT_REJ_POS:STAT_DONE_POS], 3'b010);
      chk(u_flash.ld[u_flash.n-1], CODE_RESET);
      clear();
    end
    wb(1'b0, 4'h6, 32'h0);
    chk(q, 0);
    print_verdict();
  end
endmodule : flash_ctl_test
`default_nettype wire
